// [rtl/bdsu_debug_unit.sv]
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE_01 - Four independent breakpoints, each with address, length, access type, enable.
// RULE_02 - Each breakpoint address register holds a 32-bit linear address.
// RULE_03 - Breakpoints compare linear addresses, before any physical translation.
// RULE_04 - Debug register moves allowed only in real mode, system management mode or privilege 0.
// RULE_05 - With extensions on, the two reserved slots raise invalid-opcode fault.
// RULE_06 - With extensions off, reserved slots alias to status and control.
// RULE_07 - Status register changes by hardware only when a debug exception fires.
// RULE_08 - Status bits 0-3 show which breakpoint conditions were met.
// RULE_09 - Handler checks only hit bits of enabled breakpoints.
// RULE_10 - Status bit 13 flags a debug register access, only with guard set.
// RULE_11 - Single-step enable raises a debug exception after every instruction.
// RULE_12 - Status bit 14 marks a single-step cause.
// RULE_13 - Single-step ranks highest; other bits may accompany it.
// RULE_14 - Task switch with segment trap flag raises exception, sets bit 15.
// RULE_15 - Task-switch trap has no control enable; segment trap flag only.
// RULE_16 - Exceptions may clear bits 0-3; other status bits never cleared by hardware.
// RULE_17 - Handler software should clear the status register before returning.
// RULE_18 - Resume flag suppresses repeated debug exceptions on one instruction.
// RULE_19 - Breakpoint instruction raises a breakpoint trap to the debugger.
// RULE_20 - Each branch record holds source and destination addresses.
// RULE_21 - Breakpoints fire only when enabled; local enables drop on task switch.
// RULE_22 - Guard sets bit 13 before exception on register move; cleared at entry.
// RULE_23 - Access type: 00 fetch, 01 write, 10 I/O if extensions, 11 data.
// RULE_24 - Exception is a one-cycle pulse with its status bits that cycle.
module bdsu_debug_unit #(
  parameter int NBP      = 4,
  parameter int BR_DEPTH = 4,
  parameter int BR_AW    = 2
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire bdsu_pkg::bdsu_dreq_s dreq,
  input  wire logic                 real_mode,
  input  wire logic                 system_mgmt_mode,
  input  wire logic [1:0]           current_privilege_level,
  input  wire logic                 extensions_on,
  input  wire bdsu_pkg::bdsu_acc_s  acc,
  input  wire logic                 instr_retire,
  input  wire logic                 single_step_enable,
  input  wire logic                 resume_flag,
  input  wire logic                 task_switch,
  input  wire logic                 segment_trap_flag,
  input  wire logic                 int3_exec,
  input  wire logic                 br_valid,
  input  wire bdsu_pkg::bdsu_brec_s br_rec,
  input  wire logic [BR_AW-1:0]     br_rd_idx,
  output logic                      debug_exception,
  output logic [31:0]               exc_cause,
  output logic                      protection_fault,
  output logic                      invalid_opcode_fault,
  output logic                      breakpoint_trap,
  output logic                      rd_valid,
  output logic [31:0]               rd_data,
  output logic [31:0]               debug_cause_status,
  output logic [31:0]               breakpoint_control_reg,
  output bdsu_pkg::bdsu_brec_s      br_rd_rec,
  output logic [BR_AW-1:0]          br_top_idx
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0]       bp_addr_q [NBP];
  logic [32*NBP-1:0] bp_flat;
  logic [31:0]       status_q;
  logic [31:0]       ctl_q;
  logic [31:0]       ctl_d;
  logic [NBP-1:0]    hit;
  logic [NBP-1:0]    en;
  logic              priv_ok;
  logic              rsvd;
  logic              rsvd_fault;
  logic              prot_d;
  logic              inval_d;
  logic              guard_d;
  logic              mov_ok;
  logic [2:0]        eff_idx;
  logic              ss_d;
  logic              ts_d;
  logic              exc_d;
  logic [31:0]       cause_d;
  logic              sw_wr_stat;
  logic              sw_wr_q;
  logic [31:0]       rd_mux;

  // ----------------------------------------------------------------
  // Access checks
  // ----------------------------------------------------------------
  // RULE_04 privilege gate
  assign priv_ok    = real_mode || system_mgmt_mode || (current_privilege_level == 2'h0);
  assign rsvd       = (dreq.idx == bdsu_pkg::IDX_RSVD_STAT) || (dreq.idx == bdsu_pkg::IDX_RSVD_CTL);
  assign rsvd_fault = rsvd && extensions_on;
  assign prot_d     = dreq.valid && !priv_ok;
  // RULE_05 reserved slot fault
  assign inval_d    = dreq.valid && priv_ok && rsvd_fault;
  // Guard traps the move itself, so the access is never performed
  // RULE_10 guard detection
  // RULE_22 move trapped first
  assign guard_d    = dreq.valid && priv_ok && !rsvd_fault && ctl_q[bdsu_pkg::CTL_GUARD];
  assign mov_ok     = dreq.valid && priv_ok && !rsvd_fault && !ctl_q[bdsu_pkg::CTL_GUARD];
  // RULE_06 alias to status, control
  assign eff_idx    = rsvd ? 3'(dreq.idx + bdsu_pkg::ALIAS_STEP) : dreq.idx;
  assign sw_wr_stat = mov_ok && dreq.write && (eff_idx == bdsu_pkg::IDX_STATUS);

  // ----------------------------------------------------------------
  // Breakpoint compare
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NBP; g++) begin : g_en
      assign bp_flat[32*g +: 32] = bp_addr_q[g];
      // RULE_21 local or global enable
      assign en[g] = ctl_q[bdsu_pkg::CTL_LOCAL0 + 2*g] || ctl_q[bdsu_pkg::CTL_LOCAL0 + 2*g + 1];
    end
  endgenerate

  // RULE_01 four breakpoints
  bdsu_bp_match #(
    .N           (NBP)
  ) u_match (
    .acc         (acc),
    .bp_addr     (bp_flat),
    .ctl         (ctl_q),
    .ext_on      (extensions_on),
    .resume_flag (resume_flag),
    .hit         (hit)
  );

  // ----------------------------------------------------------------
  // Exception decision
  // ----------------------------------------------------------------
  // RULE_11 step after each instruction
  assign ss_d  = instr_retire && single_step_enable;
  // RULE_15 segment trap flag only
  assign ts_d  = task_switch && segment_trap_flag;
  assign exc_d = ss_d || ts_d || guard_d || (|(hit & en));

  always_comb begin
    cause_d = 32'h0000_0000;
    // RULE_08 hit bits, enabled or not
    cause_d[NBP-1:0]             = hit;
    cause_d[bdsu_pkg::ST_REG_ACC] = guard_d;
    // RULE_12 single-step bit
    // RULE_13 step beside other causes
    cause_d[bdsu_pkg::ST_STEP]    = ss_d;
    // RULE_14 task switch bit
    cause_d[bdsu_pkg::ST_TASK]    = ts_d;
  end

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  // RULE_07 hardware update only on exception; software write also loads
  // RULE_16 only hit bits replaced
  // Software write and event in one cycle: the event's set bits win
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= bdsu_pkg::STATUS_RST;
    end else if (exc_d) begin
      status_q <= {(sw_wr_stat ? dreq.wdata[31:4] : status_q[31:4]) | cause_d[31:4],
                   cause_d[3:0]};
    end else if (sw_wr_stat) begin
      status_q <= dreq.wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_wr_q <= 1'b0;
    end else begin
      sw_wr_q <= sw_wr_stat;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Order matters: switch and handler entry override a same-cycle write
  always_comb begin
    ctl_d = ctl_q;
    if (mov_ok && dreq.write && eff_idx == bdsu_pkg::IDX_CONTROL) begin
      ctl_d = dreq.wdata;
    end
    // RULE_21 locals cleared on switch
    if (task_switch) begin
      ctl_d = ctl_d & ~bdsu_pkg::LOCAL_MASK;
    end
    // RULE_22 guard off for handler
    if (exc_d) begin
      ctl_d[bdsu_pkg::CTL_GUARD] = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= bdsu_pkg::CONTROL_RST;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // ----------------------------------------------------------------
  // Breakpoint address registers
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < NBP; g++) begin : g_addr
      // RULE_02 32-bit linear address
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          bp_addr_q[g] <= bdsu_pkg::BP_ADDR_RST;
        end else if (mov_ok && dreq.write && eff_idx == 3'(g)) begin
          bp_addr_q[g] <= dreq.wdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (eff_idx)
      bdsu_pkg::IDX_STATUS:  rd_mux = status_q;
      bdsu_pkg::IDX_CONTROL: rd_mux = ctl_q;
      default:               rd_mux = (eff_idx < 3'(NBP)) ? bp_addr_q[eff_idx[1:0]] : 32'h0;
    endcase
  end

  // Read data holds between reads; only rd_valid marks a fresh word
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= 32'h0000_0000;
    end else begin
      rd_valid <= mov_ok && !dreq.write;
      if (mov_ok && !dreq.write) begin
        rd_data <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Exception pulses to the core
  // ----------------------------------------------------------------
  // RULE_24 pulse with cause bits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_exception <= 1'b0;
      exc_cause       <= 32'h0000_0000;
    end else begin
      debug_exception <= exc_d;
      exc_cause       <= exc_d ? cause_d : 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      protection_fault     <= 1'b0;
      invalid_opcode_fault <= 1'b0;
    end else begin
      protection_fault     <= prot_d;
      invalid_opcode_fault <= inval_d;
    end
  end

  // RULE_19 breakpoint instruction trap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      breakpoint_trap <= 1'b0;
    end else begin
      breakpoint_trap <= int3_exec;
    end
  end

  assign debug_cause_status     = status_q;
  assign breakpoint_control_reg = ctl_q;

  // ----------------------------------------------------------------
  // Branch records
  // ----------------------------------------------------------------
  // RULE_20 taken branch records
  bdsu_branch_rec #(
    .DEPTH   (BR_DEPTH),
    .AW      (BR_AW)
  ) u_brec (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .br_valid(br_valid),
    .br_rec  (br_rec),
    .rd_idx  (br_rd_idx),
    .rd_rec  (br_rd_rec),
    .top_idx (br_top_idx)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  priv_fault_a: assert property (prot_d |=> protection_fault && !rd_valid)  // RULE_04
    else $error("privilege fault missing");
  rsvd_fault_a: assert property (inval_d |=> invalid_opcode_fault && !rd_valid)  // RULE_05
    else $error("reserved slot fault missing");
  alias_read_a: assert property (mov_ok && !dreq.write && rsvd  // RULE_06
    |=> rd_valid && rd_data == (($past(dreq.idx) == bdsu_pkg::IDX_RSVD_STAT) ?
        $past(status_q) : $past(ctl_q))) else $error("alias read wrong");
  status_hold_a: assert property ($changed(status_q) |-> debug_exception || sw_wr_q)  // RULE_07
    else $error("status changed without exception");
  step_cause_a: assert property (ss_d  // RULE_12
    |=> debug_exception && exc_cause[bdsu_pkg::ST_STEP] && status_q[bdsu_pkg::ST_STEP])
    else $error("single-step cause missing");
  task_cause_a: assert property (ts_d |=> debug_exception  // RULE_14
    ##0 status_q[bdsu_pkg::ST_TASK]) else $error("task switch cause missing");
  guard_entry_a: assert property (guard_d |=> status_q[bdsu_pkg::ST_REG_ACC]  // RULE_22
    && !ctl_q[bdsu_pkg::CTL_GUARD] && !rd_valid) else $error("guard trap wrong");
  local_clr_a: assert property (task_switch |=> (ctl_q & bdsu_pkg::LOCAL_MASK) == 32'h0)  // RULE_21
    else $error("local enables kept");
  sticky_bits_a: assert property (debug_exception && !sw_wr_q  // RULE_16
    |-> (status_q[31:4] & $past(status_q[31:4])) == $past(status_q[31:4]))
    else $error("upper status bit cleared");
  int3_trap_a: assert property (int3_exec |=> breakpoint_trap ##1 !breakpoint_trap || $past(int3_exec))  // RULE_19
    else $error("breakpoint trap wrong");
  pulse_once_a: assert property (!exc_d |=> !debug_exception && exc_cause == 32'h0000_0000)  // RULE_24
    else $error("exception pulse stretched");

  pulse_cause_a: assert property (debug_exception  // RULE_24
    |-> exc_cause[bdsu_pkg::ST_TASK:bdsu_pkg::ST_REG_ACC] != 3'h0 || exc_cause[3:0] != 4'h0)
    else $error("exception without cause bits");
  resume_fetch_a: assert property (resume_flag && acc.valid  // RULE_18
    && acc.kind == bdsu_pkg::ACC_FETCH |-> hit == '0) else $error("fetch hit under resume");
  disabled_bp_a: assert property ((|(hit & ~en)) && !(|(hit & en)) && !ss_d && !ts_d  // RULE_21
    && !guard_d |=> !debug_exception) else $error("disabled breakpoint fired");
  task_gate_a: assert property (task_switch && !segment_trap_flag && !sw_wr_stat  // RULE_15
    |=> status_q[bdsu_pkg::ST_TASK] == $past(status_q[bdsu_pkg::ST_TASK]))
    else $error("task switch bit set without trap flag");
  rd_hold_a: assert property (!(mov_ok && !dreq.write) |=> $stable(rd_data))  // RULE_04
    else $error("read data changed without read");
endmodule : bdsu_debug_unit
`default_nettype wire

// [shared/bdsu_pkg.sv]
`default_nettype none
package bdsu_pkg;
  // ----------------------------------------------------------------
  // Register indices of the move-to/from-debug-register port
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_BP0       = 3'h0;
  localparam logic [2:0] IDX_RSVD_STAT = 3'h4;
  localparam logic [2:0] IDX_RSVD_CTL  = 3'h5;
  localparam logic [2:0] IDX_STATUS    = 3'h6;
  localparam logic [2:0] IDX_CONTROL   = 3'h7;
  localparam logic [2:0] ALIAS_STEP    = 3'h2;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int          NUM_BP      = 4;
  localparam int          ST_HIT_W    = 4;
  localparam int          ST_REG_ACC  = 13;
  localparam int          ST_STEP     = 14;
  localparam int          ST_TASK     = 15;
  localparam int          CTL_LOCAL0  = 0;
  localparam int          CTL_GUARD   = 13;
  localparam int          CTL_RW0     = 16;
  localparam int          CTL_LEN0    = 18;
  localparam int          CTL_STRIDE  = 4;
  localparam logic [31:0] STATUS_RST  = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
  localparam logic [31:0] BP_ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] LOCAL_MASK  = 32'h0000_0055;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_FETCH = 2'h0,
    ACC_DATA  = 2'h1,
    ACC_IO    = 2'h2
  } bdsu_kind_e;

  typedef struct packed {
    logic        valid;
    bdsu_kind_e  kind;
    logic        wr;
    logic [1:0]  size;
    logic [31:0] addr;
  } bdsu_acc_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  idx;
    logic [31:0] wdata;
  } bdsu_dreq_s;

  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
  } bdsu_brec_s;
endpackage : bdsu_pkg
`default_nettype wire

// [rtl/bdsu_bp_match.sv]
`timescale 1ns/1ps
`default_nettype none
module bdsu_bp_match #(
  parameter int N = 4
) (
  input  wire bdsu_pkg::bdsu_acc_s acc,
  input  wire logic [32*N-1:0]     bp_addr,
  input  wire logic [31:0]         ctl,
  input  wire logic                ext_on,
  input  wire logic                resume_flag,
  output logic [N-1:0]             hit
);
  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  // RULE_23 access type decode
  function automatic logic type_ok(input logic [1:0] rw, input bdsu_pkg::bdsu_acc_s a,
                                   input logic ext);
    unique case (rw)
      2'h0: type_ok = (a.kind == bdsu_pkg::ACC_FETCH);
      2'h1: type_ok = (a.kind == bdsu_pkg::ACC_DATA) && a.wr;
      2'h2: type_ok = (a.kind == bdsu_pkg::ACC_IO) && ext;
      2'h3: type_ok = (a.kind == bdsu_pkg::ACC_DATA);
    endcase
  endfunction : type_ok

  function automatic logic [31:0] span(input logic [1:0] sz);
    unique case (sz)
      2'h0: span = 32'h0000_0000;
      2'h1: span = 32'h0000_0001;
      2'h2: span = 32'h0000_0007;
      2'h3: span = 32'h0000_0003;
    endcase
  endfunction : span

  // ----------------------------------------------------------------
  // Per-breakpoint compare
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bp
      logic [1:0]  rw;
      logic [1:0]  len;
      logic [31:0] lo;
      logic [32:0] hi;
      logic [32:0] a_hi;
      assign rw   = ctl[bdsu_pkg::CTL_RW0 + bdsu_pkg::CTL_STRIDE*i +: 2];
      assign len  = ctl[bdsu_pkg::CTL_LEN0 + bdsu_pkg::CTL_STRIDE*i +: 2];
      // Low address bits masked by length, as alignment is required
      assign lo   = bp_addr[32*i +: 32] & ~span(len);
      assign hi   = {1'b0, lo | span(len)};
      assign a_hi = {1'b0, acc.addr} + {1'b0, span(acc.size)};
      // RULE_03 linear compare untranslated
      // RULE_18 resume suppresses refetch
      assign hit[i] = acc.valid && type_ok(rw, acc, ext_on)
                      && !(resume_flag && acc.kind == bdsu_pkg::ACC_FETCH)
                      && ({1'b0, acc.addr} <= hi) && ({1'b0, lo} <= a_hi);
    end
  endgenerate
endmodule : bdsu_bp_match
`default_nettype wire

// [rtl/bdsu_branch_rec.sv]
`timescale 1ns/1ps
`default_nettype none
module bdsu_branch_rec #(
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 br_valid,
  input  wire bdsu_pkg::bdsu_brec_s br_rec,
  input  wire logic [AW-1:0]        rd_idx,
  output bdsu_pkg::bdsu_brec_s      rd_rec,
  output logic [AW-1:0]             top_idx
);
  bdsu_pkg::bdsu_brec_s mem_q [DEPTH];
  logic [AW-1:0]        wp_q;

  // ----------------------------------------------------------------
  // Circular record stack
  // ----------------------------------------------------------------
  // RULE_20 source and destination kept
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem_q[k] <= '0;
      end
    end else if (br_valid) begin
      mem_q[wp_q] <= br_rec;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
    end else if (br_valid) begin
      wp_q <= AW'(wp_q + 1'b1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_rec <= '0;
    end else begin
      rd_rec <= mem_q[rd_idx];
    end
  end

  assign top_idx = AW'(wp_q - 1'b1);

  // RULE_20 record pairing check
  branch_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_20
    br_valid |=> mem_q[top_idx] == $past(br_rec)) else $error("branch record lost");
endmodule : bdsu_branch_rec
`default_nettype wire

// [bench/bdsu_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bdsu_core_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        debug_exception,
  input  wire logic [31:0] debug_cause_status,
  input  wire logic [31:0] breakpoint_control_reg,
  output logic [7:0]       exc_count,
  output logic [3:0]       handler_hits
);
  // ------
  // Core exception intake
  // ------
  logic [3:0] enabled;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      exc_count <= 8'h00;
    end else if (debug_exception) begin
      exc_count <= exc_count + 8'h01;
    end
  end
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      enabled[n] = |breakpoint_control_reg[2*n +: 2];
    end
  end
  // Disabled hit bits are noise, so mask them
  assign handler_hits = debug_cause_status[3:0] & enabled;
endmodule : bdsu_core_model
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ------
  // Signals
  // ------
  logic sys_clk = 1'h0, rst_n = 1'h0;
  bdsu_pkg::bdsu_dreq_s dreq = '0;
  bdsu_pkg::bdsu_acc_s  acc = '0;
  bdsu_pkg::bdsu_brec_s br_rec = '0, br_rd_rec;
  logic real_mode = 1'h0, sm_mode = 1'h0, ext_on = 1'h0, retire = 1'h0;
  logic step_en = 1'h0, resume = 1'h0, tsw = 1'h0, trap_flag = 1'h0;
  logic int3 = 1'h0, br_valid = 1'h0, dbg, pf, inv_op, bpt, rd_valid;
  logic [1:0]  plvl = 2'h0, br_rd_idx = 2'h0, br_top_idx, idx;
  logic [31:0] cause, rd_data, status, control, exp_st, got_rd;
  logic        got_v, got_pf, got_inv, got_dbg;
  logic [7:0]  exc_count;
  logic [3:0]  handler_hits;
  int fail_count = 0, n_compared = 0, cycles = 0;
  localparam logic [31:0] BPA [4] = '{32'h8000_3000, 32'h0000_A000,
                                      32'hFFFF_FFFC, 32'h7FFF_0001};
  localparam logic [4:0] PRIV [4] = '{5'h01, 5'h06, 5'h17, 5'h0B};

  always #50 sys_clk = ~sys_clk;

  bdsu_debug_unit i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .dreq(dreq),
    .real_mode(real_mode), .system_mgmt_mode(sm_mode), .current_privilege_level(plvl),
    .extensions_on(ext_on), .acc(acc), .instr_retire(retire),
    .single_step_enable(step_en), .resume_flag(resume), .task_switch(tsw),
    .segment_trap_flag(trap_flag), .int3_exec(int3), .br_valid(br_valid),
    .br_rec(br_rec), .br_rd_idx(br_rd_idx), .debug_exception(dbg),
    .exc_cause(cause), .protection_fault(pf), .invalid_opcode_fault(inv_op),
    .breakpoint_trap(bpt), .rd_valid(rd_valid), .rd_data(rd_data),
    .debug_cause_status(status), .breakpoint_control_reg(control),
    .br_rd_rec(br_rd_rec), .br_top_idx(br_top_idx));

  bdsu_core_model i_core (.sys_clk(sys_clk), .rst_n(rst_n), .debug_exception(dbg),
    .debug_cause_status(status), .breakpoint_control_reg(control),
    .exc_count(exc_count), .handler_hits(handler_hits));

  // ------
  // Tasks
  // ------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  task automatic reg_op(input logic w, input logic [2:0] ix, input logic [31:0] d);
    @(posedge sys_clk);
    dreq <= '{1'h1, w, ix, d};
    @(posedge sys_clk);
    dreq <= '0;
    #1;
    got_v = rd_valid;
    got_rd = rd_data;
    got_pf = pf;
    got_inv = inv_op;
    got_dbg = dbg;
  endtask : reg_op

  // Event bits are {int3, task switch, retire}
  task automatic fire(input logic [2:0] ev, input bdsu_pkg::bdsu_acc_s a,
                      input logic exp_dbg);
    @(posedge sys_clk);
    {int3, tsw, retire} <= ev;
    acc <= a;
    @(posedge sys_clk);
    {int3, tsw, retire} <= 3'h0;
    acc <= '0;
    #1;
    chk_bit(dbg, exp_dbg);
    chk_word(status, exp_st);
  endtask : fire

  function automatic bdsu_pkg::bdsu_acc_s ac(input bdsu_pkg::bdsu_kind_e k,
                                             input logic w, input logic [31:0] a);
    ac = '{1'h1, k, w, 2'h0, a};
  endfunction : ac

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // Hang guard, tests need under a hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      finish_test();
    end
  end

  // ------
  // Tests
  // ------
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'h1;
    reg_op(1'h0, bdsu_pkg::IDX_STATUS, 32'h0);
    chk_word(got_rd, bdsu_pkg::STATUS_RST);
    chk_word(control, bdsu_pkg::CONTROL_RST);
    for (int i = 0; i < 4; i++) reg_op(1'h1, 3'(i), BPA[i]);
    for (int i = 0; i < 4; i++) begin
      reg_op(1'h0, 3'(i), 32'h0);
      chk_word(got_rd, BPA[i]);
    end
    $display("test registers done");
    foreach (PRIV[k]) begin
      @(posedge sys_clk) {real_mode, sm_mode, plvl} <= PRIV[k][4:1];
      reg_op(1'h0, bdsu_pkg::IDX_BP0, 32'h0);
      chk_bit(got_v, PRIV[k][0]);
      chk_bit(got_pf, ~PRIV[k][0]);
    end
    @(posedge sys_clk) {real_mode, sm_mode, plvl, ext_on} <= 5'h01;
    reg_op(1'h0, bdsu_pkg::IDX_RSVD_STAT, 32'h0);
    chk_bit(got_inv, 1'h1);
    reg_op(1'h0, bdsu_pkg::IDX_RSVD_CTL, 32'h0);
    chk_bit(got_inv, 1'h1);
    @(posedge sys_clk) ext_on <= 1'h0;
    reg_op(1'h1, bdsu_pkg::IDX_RSVD_CTL, 32'h00D0_0009);
    chk_word(control, 32'h00D0_0009);
    $display("test access guard done");
    @(posedge sys_clk) step_en <= 1'h1;
    // Step plus a hit on a disabled breakpoint: the handler must ignore it
    exp_st = 32'h0000_4004;
    fire(3'h1, ac(bdsu_pkg::ACC_FETCH, 1'h0, BPA[2]), 1'h1);
    chk_bit(cause[14], 1'h1);
    chk_word({28'h0, handler_hits}, 32'h0);
    @(posedge sys_clk) step_en <= 1'h0;
    exp_st = 32'h0000_4001;
    fire(3'h0, ac(bdsu_pkg::ACC_FETCH, 1'h0, BPA[0]), 1'h1);
    @(posedge sys_clk) resume <= 1'h1;
    fire(3'h0, ac(bdsu_pkg::ACC_FETCH, 1'h0, BPA[0]), 1'h0);
    @(posedge sys_clk) resume <= 1'h0;
    fire(3'h0, ac(bdsu_pkg::ACC_FETCH, 1'h0, BPA[2]), 1'h0);
    fire(3'h0, ac(bdsu_pkg::ACC_DATA, 1'h0, 32'h0000_A002), 1'h0);
    exp_st = 32'h0000_4002;
    fire(3'h0, ac(bdsu_pkg::ACC_DATA, 1'h1, 32'h0000_A002), 1'h1);
    chk_word({28'h0, handler_hits}, 32'h2);
    @(posedge sys_clk) trap_flag <= 1'h1;
    exp_st = 32'h0000_C000;
    fire(3'h2, '0, 1'h1);
    chk_word(control, 32'h00D0_0008);
    @(posedge sys_clk) trap_flag <= 1'h0;
    fire(3'h2, '0, 1'h0);
    $display("test events done");
    reg_op(1'h1, bdsu_pkg::IDX_CONTROL, 32'h00D0_2008);
    reg_op(1'h0, bdsu_pkg::IDX_STATUS, 32'h0);
    chk_bit(got_dbg, 1'h1);
    chk_bit(got_v, 1'h0);
    chk_word(status, 32'h0000_E000);
    chk_word(control, 32'h00D0_0008);
    reg_op(1'h1, bdsu_pkg::IDX_STATUS, 32'h0);
    reg_op(1'h0, bdsu_pkg::IDX_RSVD_STAT, 32'h0);
    chk_word(got_rd, 32'h0);
    exp_st = 32'h0;
    fire(3'h4, '0, 1'h0);
    chk_bit(bpt, 1'h1);
    $display("test guard and trap done");
    @(posedge sys_clk);
    br_valid <= 1'h1;
    br_rec <= '{32'h1234_5678, 32'h9ABC_DEF0};
    @(posedge sys_clk);
    br_valid <= 1'h0;
    #1;
    idx = br_top_idx;
    chk_word({30'h0, idx}, 32'h0);
    @(posedge sys_clk) br_rd_idx <= idx;
    repeat (2) @(posedge sys_clk);
    #1;
    chk_word(br_rd_rec.src, 32'h1234_5678);
    chk_word(br_rd_rec.dst, 32'h9ABC_DEF0);
    chk_word({24'h0, exc_count}, 32'h5);
    $display("test branch record done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
